//--- fsl_pkg.sv
// Package with constants and types for the flash security lockout block.
package fsl_pkg;
    localparam logic [15:0] SEC_WORD_ADDR  = 16'h7FF7;
    localparam logic [15:0] SEC_SECURE_VAL = 16'h0002;
    localparam logic [15:0] SEC_CLEAR_VAL  = 16'h0000;
    localparam logic [15:0] KEY_BASE_ADDR  = 16'h7FFC;
    localparam logic [15:0] ERASED_WORD    = 16'hFFFF;
    localparam int          DIV_WIDTH      = 7;
    localparam int          IR_WIDTH       = 4;
    localparam logic [3:0]  IR_IDCODE      = 4'h2;
    localparam logic [3:0]  IR_LOCKOUT_REC = 4'h8;
    localparam logic [3:0]  IR_BYPASS      = 4'hF;
    localparam logic [3:0]  IR_RESET_VAL   = 4'h2;
    localparam logic [6:0]  DIV_RESET_VAL  = 7'h00;
    localparam int          FLASH_WORDS    = 16;
    localparam logic [31:0] IDCODE_VAL     = 32'h1000_0001;
    typedef enum logic [3:0] {
        ER_IDLE = 4'b0001,
        ER_WAIT = 4'b0010,
        ER_WIPE = 4'b0100,
        ER_DONE = 4'b1000
    } fsl_erase_type;
endpackage : fsl_pkg

//--- fsl_tap.sv
// Test access port state machine with instruction and data registers.
module fsl_tap (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       tck_rise,
    input  wire logic       tms,
    input  wire logic       tdi,
    output logic            tdo,
    output logic            run_idle,
    output logic            test_reset,
    output logic [3:0]      ir_value,
    output logic [6:0]      div_value
);
    // States of the standard sixteen-state controller, in one-hot codes.
    typedef enum logic [15:0] {
        TLR = 16'h0001, RTI = 16'h0002, SDS = 16'h0004, CDR = 16'h0008,
        SDR = 16'h0010, E1D = 16'h0020, PDR = 16'h0040, E2D = 16'h0080,
        UDR = 16'h0100, SIS = 16'h0200, CIR = 16'h0400, SIR = 16'h0800,
        E1I = 16'h1000, PIR = 16'h2000, E2I = 16'h4000, UIR = 16'h8000
    } fsl_tap_type;
    fsl_tap_type state_r;
    fsl_tap_type state_nxt;
    logic [3:0]  ir_sh_r;
    logic [31:0] dr_sh_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            TLR: state_nxt = tms ? TLR : RTI;
            RTI: state_nxt = tms ? SDS : RTI;
            SDS: state_nxt = tms ? SIS : CDR;
            CDR: state_nxt = tms ? E1D : SDR;
            SDR: state_nxt = tms ? E1D : SDR;
            E1D: state_nxt = tms ? UDR : PDR;
            PDR: state_nxt = tms ? E2D : PDR;
            E2D: state_nxt = tms ? UDR : SDR;
            UDR: state_nxt = tms ? SDS : RTI;
            SIS: state_nxt = tms ? TLR : CIR;
            CIR: state_nxt = tms ? E1I : SIR;
            SIR: state_nxt = tms ? E1I : SIR;
            E1I: state_nxt = tms ? UIR : PIR;
            PIR: state_nxt = tms ? E2I : PIR;
            E2I: state_nxt = tms ? UIR : SIR;
            UIR: state_nxt = tms ? SDS : RTI;
            default: state_nxt = TLR;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_r <= TLR;
        end else if (tck_rise) begin
            state_r <= state_nxt;
        end
    end

    // The ID code stays reachable regardless of security.
    always_ff @(posedge clock) begin
        if (reset) begin
            ir_sh_r   <= 4'h0;
            dr_sh_r   <= 32'h0000_0000;
            ir_value  <= fsl_pkg::IR_RESET_VAL;
            div_value <= fsl_pkg::DIV_RESET_VAL;
        end else if (tck_rise) begin
            case (state_r)
                TLR: ir_value <= fsl_pkg::IR_RESET_VAL;
                CIR: ir_sh_r <= 4'h1;
                SIR: ir_sh_r <= {tdi, ir_sh_r[3:1]};
                UIR: ir_value <= ir_sh_r;
                CDR: begin
                    if (ir_value == fsl_pkg::IR_IDCODE) begin
                        dr_sh_r <= fsl_pkg::IDCODE_VAL;
                    end else begin
                        dr_sh_r <= {25'h000_0000, div_value};
                    end
                end
                SDR: begin
                    if (ir_value == fsl_pkg::IR_LOCKOUT_REC) begin
                        dr_sh_r <= {25'h000_0000, tdi, dr_sh_r[6:1]};
                    end else if (ir_value == fsl_pkg::IR_IDCODE) begin
                        dr_sh_r <= {tdi, dr_sh_r[31:1]};
                    end else begin
                        dr_sh_r <= {31'h0000_0000, tdi};
                    end
                end
                UDR: begin
                    if (ir_value == fsl_pkg::IR_LOCKOUT_REC) begin
                        div_value <= dr_sh_r[6:0];
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tdo        <= 1'b0;
            run_idle   <= 1'b0;
            test_reset <= 1'b1;
        end else begin
            tdo        <= (state_r == SIR) ? ir_sh_r[0] : dr_sh_r[0];
            run_idle   <= (state_r == RTI);
            test_reset <= (state_r == TLR);
        end
    end

    idcode_cap_a: assert property (@(posedge clock) disable iff (reset)
        tck_rise && state_r == CDR && ir_value == fsl_pkg::IR_IDCODE
        |=> dr_sh_r == fsl_pkg::IDCODE_VAL)
        else $error("ID code not captured");
    div_load_a: assert property (@(posedge clock) disable iff (reset)
        tck_rise && state_r == UDR && ir_value == fsl_pkg::IR_LOCKOUT_REC
        |=> div_value == $past(dr_sh_r[6:0]))
        else $error("divider value not loaded");
endmodule : fsl_tap

//--- fsl_lockout.sv
// Flash security and debug lockout top level with lockout recovery erase.
module fsl_lockout (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        tck,
    input  wire logic        tms,
    input  wire logic        tdi,
    output logic             tdo,
    input  wire logic        dbg_rd,
    input  wire logic [15:0] dbg_addr,
    output logic [15:0]      dbg_rdata,
    output logic             dbg_valid,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [15:0] cpu_wdata,
    input  wire logic        key_en,
    input  wire logic [15:0] key_word,
    output logic [15:0]      cpu_rdata,
    output logic             secured,
    output logic             debug_enable,
    output logic             erase_busy,
    output logic             erase_done
);
    // A blank part starts out erased.
    logic [15:0] flash_array [fsl_pkg::FLASH_WORDS] = '{default: fsl_pkg::ERASED_WORD};
    logic        tck_r;
    logic        tck_rise;
    logic        run_idle;
    logic        test_reset;
    logic [3:0]  ir_value;
    logic [6:0]  div_value;
    logic [6:0]  div_cnt_r;
    logic [4:0]  wipe_idx_r;
    logic        started_r;
    logic [1:0]  key_cnt_r;
    logic        key_ok_r;
    fsl_pkg::fsl_erase_type er_r;

    function automatic logic [3:0] fidx(input logic [15:0] addr);
        fidx = addr[3:0];
    endfunction : fidx

    always_ff @(posedge clock) begin
        if (reset) begin
            tck_r <= 1'b0;
        end else begin
            tck_r <= tck;
        end
    end
    assign tck_rise = tck & ~tck_r;

    // All four pins reach the test port.
    fsl_tap u_tap (
        .clock      (clock),
        .reset      (reset),
        .tck_rise   (tck_rise),
        .tms        (tms),
        .tdi        (tdi),
        .tdo        (tdo),
        .run_idle   (run_idle),
        .test_reset (test_reset),
        .ir_value   (ir_value),
        .div_value  (div_value)
    );

    // Erase runs from Run-Test/Idle under the recovery instruction.
    always_ff @(posedge clock) begin
        if (reset) begin
            er_r       <= fsl_pkg::ER_IDLE;
            div_cnt_r  <= 7'h00;
            wipe_idx_r <= 5'h00;
        end else begin
            case (er_r)
                fsl_pkg::ER_IDLE: begin
                    if (run_idle && ir_value == fsl_pkg::IR_LOCKOUT_REC) begin
                        er_r <= fsl_pkg::ER_WAIT;
                    end
                end
                fsl_pkg::ER_WAIT: begin
                    div_cnt_r  <= div_value;
                    wipe_idx_r <= 5'h00;
                    er_r       <= fsl_pkg::ER_WIPE;
                end
                fsl_pkg::ER_WIPE: begin
                    if (div_cnt_r != 7'h00) begin
                        div_cnt_r <= div_cnt_r - 7'h01;
                    end else if (wipe_idx_r == 5'(fsl_pkg::FLASH_WORDS - 1)) begin
                        er_r <= fsl_pkg::ER_DONE;
                    end else begin
                        div_cnt_r  <= div_value;
                        wipe_idx_r <= wipe_idx_r + 5'h01;
                    end
                end
                fsl_pkg::ER_DONE: begin
                    if (test_reset) begin
                        er_r <= fsl_pkg::ER_IDLE;
                    end
                end
                default: er_r <= fsl_pkg::ER_IDLE;
            endcase
        end
    end

    // The array is not cleared by reset, so the stored word survives it.
    always_ff @(posedge clock) begin
        if (er_r == fsl_pkg::ER_WIPE && div_cnt_r == 7'h00) begin
            flash_array[wipe_idx_r[3:0]] <= fsl_pkg::ERASED_WORD;
        end else if (cpu_wr && er_r == fsl_pkg::ER_IDLE) begin
            // Programming only moves bits from one to zero.
            flash_array[fidx(cpu_addr)] <= flash_array[fidx(cpu_addr)] & cpu_wdata;
        end
    end

    // Key accesses may have idle gaps; a mismatch, or a CPU read or write in a cycle without key_en, restarts the count.
    always_ff @(posedge clock) begin
        if (reset) begin
            key_cnt_r <= 2'h0;
            key_ok_r  <= 1'b0;
        end else if (key_en) begin
            if (key_word == flash_array[fidx(fsl_pkg::KEY_BASE_ADDR) + key_cnt_r]) begin
                key_cnt_r <= key_cnt_r + 2'h1;
                if (key_cnt_r == 2'h3) begin
                    key_ok_r <= 1'b1;
                end
            end else begin
                key_cnt_r <= 2'h0;
            end
        end else if (cpu_rd || cpu_wr) begin
            key_cnt_r <= 2'h0;
        end
    end

    // Security is sampled as reset releases and held afterward until a key match clears it.
    always_ff @(posedge clock) begin
        if (reset) begin
            started_r <= 1'b0;
            secured   <= 1'b1;
        end else if (!started_r) begin
            started_r <= 1'b1;
            secured   <= (flash_array[fidx(fsl_pkg::SEC_WORD_ADDR)]
                          == fsl_pkg::SEC_SECURE_VAL);
        end else if (key_ok_r) begin
            secured <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            debug_enable <= 1'b0;
            dbg_rdata    <= 16'h0000;
            dbg_valid    <= 1'b0;
            cpu_rdata    <= 16'h0000;
            erase_busy   <= 1'b0;
            erase_done   <= 1'b0;
        end else begin
            debug_enable <= started_r && !secured && !key_ok_r ? 1'b1 :
                            (started_r && key_ok_r);
            dbg_valid    <= dbg_rd && started_r && !secured;
            dbg_rdata    <= (dbg_rd && started_r && !secured) ?
                            flash_array[fidx(dbg_addr)] : 16'h0000;
            cpu_rdata    <= flash_array[fidx(cpu_addr)];
            erase_busy   <= (er_r == fsl_pkg::ER_WAIT) || (er_r == fsl_pkg::ER_WIPE);
            erase_done   <= (er_r == fsl_pkg::ER_DONE);
        end
    end

    secure_reset_a: assert property (@(posedge clock) reset |=> secured)
        else $error("secured not set during reset");
    debug_block_a: assert property (@(posedge clock) disable iff (reset)
        secured |=> !dbg_valid)
        else $error("debug flash read while secured");
    dbg_zero_a: assert property (@(posedge clock) disable iff (reset)
        secured |=> dbg_rdata == 16'h0000)
        else $error("debug read data not blocked");
    debug_off_a: assert property (@(posedge clock) disable iff (reset)
        secured && !key_ok_r |=> !debug_enable)
        else $error("debug enabled while secured");
    debug_on_a: assert property (@(posedge clock) disable iff (reset)
        started_r && !secured |=> debug_enable)
        else $error("debug not enabled while unsecured");
    erase_start_a: assert property (@(posedge clock) disable iff (reset)
        er_r == fsl_pkg::ER_IDLE && run_idle && ir_value == fsl_pkg::IR_LOCKOUT_REC
        |=> er_r == fsl_pkg::ER_WAIT)
        else $error("erase did not start in run idle");
    erase_busy_a: assert property (@(posedge clock) disable iff (reset)
        er_r == fsl_pkg::ER_WAIT |=> erase_busy)
        else $error("erase busy not shown");
    wipe_write_a: assert property (@(posedge clock) disable iff (reset)
        er_r == fsl_pkg::ER_WIPE && div_cnt_r == 7'h00
        |=> flash_array[$past(wipe_idx_r[3:0])] == fsl_pkg::ERASED_WORD)
        else $error("erased word not written");
    erase_end_a: assert property (@(posedge clock) disable iff (reset)
        er_r == fsl_pkg::ER_DONE |=> erase_done)
        else $error("erase done not shown");
    erase_hold_a: assert property (@(posedge clock) disable iff (reset)
        er_r == fsl_pkg::ER_DONE && !test_reset |=> er_r == fsl_pkg::ER_DONE)
        else $error("done left without test reset");
    key_unlock_a: assert property (@(posedge clock) disable iff (reset)
        started_r && key_ok_r |=> !secured)
        else $error("key match did not unsecure");
    sec_hold_a: assert property (@(posedge clock) disable iff (reset)
        started_r && secured && !key_ok_r |=> secured)
        else $error("secured state dropped without key");
    sec_sample_a: assert property (@(posedge clock) disable iff (reset)
        !started_r |=> secured == $past(flash_array[fidx(fsl_pkg::SEC_WORD_ADDR)]
        == fsl_pkg::SEC_SECURE_VAL))
        else $error("security word not sampled at reset exit");
endmodule : fsl_lockout

//--- fsl_host.sv
// Debug host model that drives the test port pins of the lockout block.
module fsl_host (
    input  wire logic clock,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tdo_seen;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One test clock period; the test clock stands low between calls.
    task automatic tick(input logic m, input logic d);
        @(negedge clock);
        tms = m;
        tdi = d;
        repeat (4) @(negedge clock);
        tdo_seen = tdo;
        tck = 1'b1;
        repeat (4) @(negedge clock);
        tck = 1'b0;
    endtask : tick
    task automatic tap_reset();
        repeat (5) tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
    endtask : tap_reset
    // Starts in idle or update, shifts n bits lsb first and ends in update.
    task automatic shift(input logic ir, input logic [31:0] val, input int n,
                         output logic [31:0] got);
        got = '0;
        tick(1'b1, 1'b0);
        if (ir) tick(1'b1, 1'b0);
        tick(1'b0, 1'b0);
        tick(1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, val[i]);
            got[i] = tdo_seen;
        end
        tick(1'b1, 1'b0);
    endtask : shift
    // The divider goes in before idle is entered, so the erase sees it.
    task automatic recover(input logic [6:0] div);
        logic [31:0] unused;
        shift(1'b1, 32'(fsl_pkg::IR_LOCKOUT_REC), fsl_pkg::IR_WIDTH, unused);
        shift(1'b0, 32'(div), fsl_pkg::DIV_WIDTH, unused);
        tick(1'b0, 1'b0);
    endtask : recover
endmodule : fsl_host

//--- fsl_lockout_test.sv
// Self-checking bench for the flash security lockout block.
module fsl_lockout_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, reset, tck, tms, tdi, tdo, dbg_rd, dbg_valid, cpu_wr, cpu_rd;
    logic        key_en, secured, debug_enable, erase_busy, erase_done;
    logic [15:0] dbg_addr, dbg_rdata, cpu_addr, cpu_wdata, key_word, cpu_rdata;
    logic [15:0] key [4];
    logic [31:0] seed, got;
    int          err_count, checks_done;
    int          busy_cycles = 0;
    fsl_lockout u_fsl_lockout (.clock(clock), .reset(reset), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .dbg_rd(dbg_rd), .dbg_addr(dbg_addr),
        .dbg_rdata(dbg_rdata), .dbg_valid(dbg_valid), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .key_en(key_en), .key_word(key_word),
        .cpu_rdata(cpu_rdata), .secured(secured), .debug_enable(debug_enable),
        .erase_busy(erase_busy), .erase_done(erase_done));
    fsl_host u_fsl_host (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : next_rand
    function automatic logic exp_secured(input logic [15:0] w);
        return w === fsl_pkg::SEC_SECURE_VAL;
    endfunction : exp_secured
    // Every word takes the divider count plus one cycle, and the wait state adds one more.
    function automatic logic [15:0] exp_busy(input logic [6:0] div);
        return 16'(fsl_pkg::FLASH_WORDS * (int'(div) + 1) + 1);
    endfunction : exp_busy
    task automatic stop_test();
        if (err_count == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: word %h expected %h", $time, g, e);
        end
    endtask : chk_word
    task automatic chk_flag(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("mismatch at %0t: flag %b expected %b", $time, g, e);
        end
    endtask : chk_flag
    task automatic reset_dev();
        @(negedge clock);
        reset = 1'b1;
        repeat (6) @(negedge clock);
        chk_flag(secured, 1'b1);
        reset = 1'b0;
        repeat (2) @(negedge clock);
    endtask : reset_dev
    task automatic cpu_op(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(negedge clock);
        cpu_wr = wr;
        cpu_rd = !wr;
        cpu_addr = a;
        cpu_wdata = d;
        @(negedge clock);
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
    endtask : cpu_op
    task automatic dbg_read(input logic [15:0] a, input logic v, input logic [15:0] d);
        @(negedge clock);
        dbg_rd = 1'b1;
        dbg_addr = a;
        @(negedge clock);
        dbg_rd = 1'b0;
        chk_flag(dbg_valid, v);
        chk_word(dbg_rdata, d);
    endtask : dbg_read
    task automatic send_key(input logic bad);
        for (int i = 0; i < 4; i++) begin
            @(negedge clock);
            key_en = 1'b1;
            key_word = key[i] ^ {15'h0000, bad && i == 3};
        end
        @(negedge clock);
        key_en = 1'b0;
        repeat (2) @(negedge clock);
    endtask : send_key
    task automatic wait_erase(input logic want_done);
        int n;
        n = 0;
        while ((want_done ? erase_done : erase_busy) !== 1'b1 && n < 3000) begin
            @(negedge clock);
            n++;
        end
        if (n == 3000) begin
            err_count++;
            $display("mismatch at %0t: erase wait timed out", $time);
            stop_test();
        end
    endtask : wait_erase
    always @(posedge clock) begin
        if (erase_busy === 1'b1) begin
            busy_cycles <= busy_cycles + 1;
        end
    end
    // Full recovery from idle or reset, then checks that every word reads erased.
    task automatic run_recovery(input logic [6:0] div);
        int b;
        b = busy_cycles;
        u_fsl_host.tick(1'b0, 1'b0);
        u_fsl_host.recover(div);
        wait_erase(1'b0);
        wait_erase(1'b1);
        cpu_op(1'b1, 16'h7FF0, 16'h0000);
        chk_word(16'(busy_cycles - b), exp_busy(div));
        chk_flag(erase_busy, 1'b0);
        u_fsl_host.tap_reset();
        reset_dev();
        chk_flag(secured, 1'b0);
        chk_flag(erase_done, 1'b0);
        chk_flag(debug_enable, 1'b1);
        for (int i = 0; i < 16; i++) begin
            cpu_op(1'b0, 16'h7FF0 + 16'(i), 16'h0000);
            chk_word(cpu_rdata, fsl_pkg::ERASED_WORD);
        end
    endtask : run_recovery
    initial begin
        {reset, dbg_rd, cpu_wr, cpu_rd, key_en} = 5'h1F & 5'h10;
        {dbg_addr, cpu_addr, cpu_wdata, key_word} = '0;
        err_count = 0;
        checks_done = 0;
        seed = 32'h0000_D954;
        reset_dev();
        chk_flag(secured, exp_secured(fsl_pkg::ERASED_WORD));
        seed = next_rand(seed);
        cpu_op(1'b1, 16'h7FF0, seed[15:0]);
        cpu_op(1'b1, fsl_pkg::SEC_WORD_ADDR, fsl_pkg::SEC_SECURE_VAL);
        reset_dev();
        chk_flag(secured, 1'b1);
        chk_flag(debug_enable, 1'b0);
        dbg_read(16'h7FF0, 1'b0, 16'h0000);
        u_fsl_host.tick(1'b0, 1'b0);
        u_fsl_host.shift(1'b0, 32'h0000_0000, 32, got);
        chk_word(got[15:0], fsl_pkg::IDCODE_VAL[15:0]);
        chk_word(got[31:16], fsl_pkg::IDCODE_VAL[31:16]);
        run_recovery(7'h7F);
        for (int i = 0; i < 4; i++) begin
            seed = next_rand(seed);
            key[i] = seed[15:0];
            cpu_op(1'b1, fsl_pkg::KEY_BASE_ADDR + 16'(i), key[i]);
        end
        cpu_op(1'b1, fsl_pkg::SEC_WORD_ADDR, fsl_pkg::SEC_SECURE_VAL);
        reset_dev();
        chk_flag(secured, exp_secured(fsl_pkg::SEC_SECURE_VAL));
        chk_flag(debug_enable, 1'b0);
        cpu_op(1'b0, fsl_pkg::KEY_BASE_ADDR, 16'h0000);
        chk_word(cpu_rdata, key[0]);
        dbg_read(fsl_pkg::KEY_BASE_ADDR, 1'b0, 16'h0000);
        send_key(1'b1);
        chk_flag(secured, 1'b1);
        send_key(1'b0);
        chk_flag(secured, 1'b0);
        dbg_read(fsl_pkg::KEY_BASE_ADDR, 1'b1, key[0]);
        reset_dev();
        chk_flag(secured, 1'b1);
        seed = next_rand(seed);
        run_recovery({4'h0, seed[2:0]});
        cpu_op(1'b1, fsl_pkg::SEC_WORD_ADDR, fsl_pkg::SEC_SECURE_VAL);
        reset_dev();
        chk_flag(secured, 1'b1);
        cpu_op(1'b1, fsl_pkg::SEC_WORD_ADDR, fsl_pkg::SEC_CLEAR_VAL);
        chk_flag(secured, 1'b1);
        u_fsl_host.tap_reset();
        reset_dev();
        chk_flag(secured, 1'b0);
        dbg_read(fsl_pkg::SEC_WORD_ADDR, 1'b1, fsl_pkg::SEC_CLEAR_VAL);
        stop_test();
    end
endmodule : fsl_lockout_test
